// ===== sdut_pkg.sv
// Package with constants for the scan driven up timer.
package sdut_pkg;
  // Resolution select codes.
  localparam logic [1:0] RES_1MS = 2'h0;
  localparam logic [1:0] RES_10MS = 2'h1;
  localparam logic [1:0] RES_100MS = 2'h2;
  // Clock rate and base tick period.
  localparam int CLK_HZ = 125000000;
  localparam int TICK_NS = 1000000;
  localparam int CLK_NS = 8;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  // Base periods in milliseconds.
  localparam int RES1_MS = 1;
  localparam int RES2_MS = 10;
  localparam int RES3_MS = 100;
  localparam int CNT_W = 16;
  localparam logic [15:0] PV_RESET = 16'h0000;
endpackage

// ===== sdut_timer.sv
// Scan driven general up timer with output contact.
`timescale 1ns/10ps
module sdut_timer #(
  parameter int TICK_CYC = sdut_pkg::TICK_CYCLES,
  parameter int W = sdut_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic drive_input,
  input wire logic scan_end,
  input wire logic [1:0] resolution,
  input wire logic [W-1:0] set_value,
  output logic [W-1:0] present_value,
  output logic timer_output_contact,
  output logic driven_output
);
  localparam int TW = $clog2(TICK_CYC + 1);

  // Free running time base counter and its one cycle millisecond enable.
  logic [TW-1:0] tick_cnt_reg;
  logic ms_tick;
  // Unit divider; it counts millisecond ticks within one resolution unit.
  logic [6:0] sub_ms_reg;
  logic [6:0] ms_per_unit;
  logic unit_done;
  // Units that elapsed since the last scan and wait to be applied.
  logic [W-1:0] pend_reg;
  // Present value, the sum that a scan would load, and the contact.
  logic [W-1:0] pv_reg;
  logic [W:0] scan_sum;
  logic scan_reached;
  logic contact_reg;

  // Free running millisecond time base as an enable pulse.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_reg <= '0;
    end else if (tick_cnt_reg == TW'(TICK_CYC - 1)) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end
  assign ms_tick = (tick_cnt_reg == TW'(TICK_CYC - 1));

  // Milliseconds per count for a resolution code. The spare code 3 falls
  // back to the finest base, so a stray code never stalls the timer.
  function automatic logic [6:0] unit_ms(input logic [1:0] code);
    logic [6:0] ms;
    unique case (code)
      sdut_pkg::RES_10MS: ms = 7'(sdut_pkg::RES2_MS);
      sdut_pkg::RES_100MS: ms = 7'(sdut_pkg::RES3_MS);
      default: ms = 7'(sdut_pkg::RES1_MS);
    endcase
    return ms;
  endfunction

  // The divider length follows the resolution input level.
  assign ms_per_unit = unit_ms(resolution);

  // A unit ends on the millisecond tick that completes the chosen count.
  // The divider only advances while driven, but the time base runs free,
  // so the first unit can be short by up to one millisecond and the contact then waits for a scan end.
  assign unit_done = drive_input && ms_tick
    && (sub_ms_reg + 7'h01 >= ms_per_unit);

  // Unit divider; its phase restarts whenever the drive input drops.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sub_ms_reg <= '0;
    end else if (!drive_input) begin
      sub_ms_reg <= '0;
    end else if (unit_done) begin
      sub_ms_reg <= '0;
    end else if (ms_tick) begin
      sub_ms_reg <= sub_ms_reg + 7'h01;
    end
  end

  // Pending units accumulate between scans and are handed over at scan
  // end. A unit that ends on the scan edge itself is kept for the next
  // scan, so no unit is lost or counted twice. The store saturates
  // rather than wrapping, which only matters for a stalled program.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_reg <= '0;
    end else if (!drive_input) begin
      pend_reg <= '0;
    end else if (scan_end) begin
      pend_reg <= W'(unit_done);
    end else if (unit_done && pend_reg != '1) begin
      pend_reg <= pend_reg + 1'b1;
    end
  end

  // What the next scan would load; one bit wider so that it cannot wrap.
  assign scan_sum = {1'b0, pv_reg} + {1'b0, pend_reg};
  assign scan_reached = scan_sum >= {1'b0, set_value};

  // Present value update once per scan; it stops at the set value.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pv_reg <= W'(sdut_pkg::PV_RESET);
    end else if (!drive_input) begin
      pv_reg <= W'(sdut_pkg::PV_RESET);
    end else if (scan_end && scan_reached) begin
      pv_reg <= set_value;
    end else if (scan_end) begin
      pv_reg <= scan_sum[W-1:0];
    end
  end

  // Output contact; the compare is taken only at scan end, so a set value
  // changed in mid-scan takes effect at the next scan.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      contact_reg <= 1'b0;
    end else if (!drive_input) begin
      contact_reg <= 1'b0;
    end else if (scan_end) begin
      contact_reg <= scan_reached;
    end
  end

  assign present_value = pv_reg;
  assign timer_output_contact = contact_reg;
  assign driven_output = contact_reg;

  // Checks of the timer behaviour.
  a_drop_clears: assert property (
    @(posedge clk) disable iff (!resetn)
    !drive_input |=> (pv_reg == '0 && !contact_reg))
    else $error("Drive drop did not clear timer.");

  a_scan_only: assert property (
    @(posedge clk) disable iff (!resetn)
    (drive_input && $past(drive_input) && !$past(scan_end))
    |-> $stable(pv_reg))
    else $error("Count changed outside scan end.");

  a_contact_eq: assert property (
    @(posedge clk) disable iff (!resetn)
    contact_reg |-> pv_reg == set_value || $changed(set_value))
    else $error("Contact on without count at set value.");

  a_hold_set: assert property (
    @(posedge clk) disable iff (!resetn)
    (contact_reg && drive_input && $stable(set_value)) |=>
    (!drive_input || (contact_reg && $stable(pv_reg))))
    else $error("Count or contact did not hold.");

  a_count_up: assert property (
    @(posedge clk) disable iff (!resetn)
    (drive_input && $past(drive_input) && $past(scan_end) && !contact_reg)
    |-> pv_reg >= $past(pv_reg))
    else $error("Count went down while driven.");

  a_no_drive: assert property (
    @(posedge clk) disable iff (!resetn)
    !drive_input |=> pend_reg == '0)
    else $error("Units counted without drive.");

  a_below_off: assert property (
    @(posedge clk) disable iff (!resetn)
    (scan_end && drive_input && pend_reg == '0 && pv_reg < set_value
     && !ms_tick) |=> !contact_reg)
    else $error("Contact on before set time.");

  a_out_follow: assert property (
    @(posedge clk) disable iff (!resetn)
    driven_output == timer_output_contact)
    else $error("Driven output differs from contact.");

  // Checks on the divider, the pending store and the scan compare.
  a_idle_divider: assert property (
    @(posedge clk) disable iff (!resetn)
    !drive_input |=> sub_ms_reg == '0)
    else $error("Divider ran without drive.");

  a_unit_stored: assert property (
    @(posedge clk) disable iff (!resetn)
    (drive_input && unit_done && !scan_end && pend_reg != '1)
    |=> pend_reg != $past(pend_reg))
    else $error("Elapsed unit was not stored.");

  a_reach_loads: assert property (
    @(posedge clk) disable iff (!resetn)
    (drive_input && scan_end
     && {1'b0, pv_reg} + {1'b0, pend_reg} >= {1'b0, set_value})
    |=> (contact_reg && pv_reg == $past(set_value)))
    else $error("Scan at set value did not set contact.");

  a_scan_contact: assert property (
    @(posedge clk) disable iff (!resetn)
    (drive_input && $past(drive_input) && !$past(scan_end))
    |-> $stable(contact_reg))
    else $error("Contact changed outside scan end.");

  // Main scenarios: reaching, dropping, counting, slow base, spare code.
  c_reach: cover property (@(posedge clk) disable iff (!resetn)
    $rose(contact_reg));
  c_drop: cover property (@(posedge clk) disable iff (!resetn)
    contact_reg ##1 !drive_input);
  c_count: cover property (@(posedge clk) disable iff (!resetn)
    scan_end && pend_reg != '0);
  c_slow_res: cover property (@(posedge clk) disable iff (!resetn)
    $rose(contact_reg) && resolution == sdut_pkg::RES_100MS);
  c_spare_code: cover property (@(posedge clk) disable iff (!resetn)
    $rose(contact_reg) && resolution == 2'h3);
endmodule

// ===== sdut_dummy_unused.sv
// Intentionally empty.
`timescale 1ns/10ps

// ===== sdut_prog_model.sv
// Model of the scanned program that strobes the end of each scan.
`timescale 1ns/10ps
module sdut_prog_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  output logic scan_end
);
  int gap;
  // Scan length varies, as program paths differ from scan to scan.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scan_end <= 1'b0;
      gap <= 0;
    end else begin
      scan_end <= #1 run && gap == 0;
      gap <= #1 gap == 0 ? int'($urandom % 4) : gap - 1;
    end
  end
endmodule

// ===== test_scan_driven_up_timer.sv
// Self-checking bench for the scan driven up timer.
`timescale 1ns/10ps
module test_scan_driven_up_timer;
  logic clk, resetn, drive_input, run, scan_end, chk, contact, drv;
  logic [1:0] resolution;
  logic [15:0] set_value, present_value, data_reg;
  logic [17:0] q[$];
  logic [17:0] e;
  int errors, samples_checked, ms;
  sdut_timer #(.TICK_CYC(4)) DUT (.clk(clk), .resetn(resetn),
    .drive_input(drive_input), .scan_end(scan_end),
    .resolution(resolution), .set_value(set_value),
    .present_value(present_value), .timer_output_contact(contact),
    .driven_output(drv));
  sdut_prog_model prog (.clk(clk), .resetn(resetn), .run(run),
    .scan_end(scan_end));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // A pv of ffff in a note means the count itself is not judged.
  task automatic note(input logic c, input logic [15:0] pv);
    q.push_back({c, c, pv});
    chk = 1'b1;
    cyc(1);
    chk = 1'b0;
  endtask
  // Monitor takes the oldest note whenever a sample is flagged. It looks
  // at the falling edge, where outputs launched by the rising edge settle.
  always @(negedge clk) begin
    if (chk === 1'b1) begin
      e = q.pop_front();
      check(16'(contact), 16'(e[17]));
      check(16'(drv), 16'(e[16]));
      if (e[15:0] !== 16'hffff) check(present_value, e[15:0]);
    end
  end
  // Free running bench clock.
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // Watchdog, well beyond the longest expected run.
  initial begin
    #400000;
    errors++;
    final_report();
  end
  // Main sequence over every resolution code.
  initial begin
    resetn = 0; drive_input = 0; run = 0; chk = 0;
    resolution = 2'h0; set_value = 16'h0000; data_reg = 16'h0000;
    void'($urandom(32'h552cf766));
    cyc(4);
    resetn = 1;
    for (int r = 0; r < 3; r++) begin
      ms = r == 0 ? 1 : r == 1 ? 10 : 100;
      data_reg = 16'(2 + $urandom % 5);
      set_value = r == 1 ? data_reg : 16'(3 + r);
      resolution = 2'(r);
      run = 1;
      cyc(3);
      note(0, 16'h0000);
      drive_input = 1;
      cyc(ms * 4 * int'(set_value) / 3);
      run = 0;
      cyc(2);
      note(0, 16'hffff);
      cyc(ms * 8 * int'(set_value));
      note(0, 16'hffff);
      run = 1;
      cyc(12);
      note(1, set_value);
      drive_input = 0;
    end
    // Spare code 3 times at 1 ms; a power loss clears a reached contact.
    resolution = 2'h3;
    set_value = 16'h0001;
    cyc(3);
    note(0, 16'h0000);
    drive_input = 1;
    cyc(16);
    note(1, 16'h0001);
    resetn = 0;
    cyc(2);
    note(0, 16'h0000);
    resetn = 1;
    cyc(20);
    note(1, 16'h0001);
    drive_input = 0;
    cyc(3);
    note(0, 16'h0000);
    cyc(2);
    final_report();
  end
endmodule
